// ---- rtl/cs_conv_seq.sv ----
// conversion sequencer with Avalon-MM register file for a 10-bit converter
// Summary of operation
// R1: writing one to start begins a conversion; free running needs only first.
// R2: first conversion after enabling lasts 25 converter clocks, others 13.
// R3: start reads one while converting, clears at completion; zero writes ignored.
// R4: with auto trigger on, selected source rising edge starts a conversion.
// R5: done flag sets when conversion finishes and result is updated.
// R6: done flag clears on interrupt acknowledge or by writing one.
// R7: interrupt request is flag and irq enable and global enable.
// R8: software avoids read-modify-write on control a; flag would be cleared.
// R9: prescale code 0..7 divides by 2,2,4,8,16,32,64,128.
// R10: right adjusted: result 9:8 in high bits 1:0, 7:0 in low.
// R11: left adjusted: result 9:2 in high, 1:0 in low bits 7:6.
// R12: after a low byte read, result holds until high byte is read.
// R13: software reads low byte before high, or high only when left adjusted.
// R14: software writes zero to reserved bit 7 of control b.
// R15: trigger source select has no effect while auto trigger is off.
// R16: trigger codes: free run, comparator, ext irq0, timers and capture.
// R17: rising edge of selected flag triggers; switching to a set source counts.
// R18: selecting free running never creates a trigger event.
// R19: pin disable bits mask the port input reading to zero.
// R20: clearing enable turns converter off and aborts a running conversion.
// R21: reference and channel changes apply only after the current conversion.
// R22: left adjust changes result presentation immediately.
// R23: free running with auto trigger restarts at each completion.
module cs_conv_seq
	import cs_pkg::*;
#(
	parameter int N_PINS = 8
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// avalon-mm slave
	input wire logic [CS_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [CS_DATA_W-1:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [CS_DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// interrupt system
	input wire logic global_irq_enable_i,
	input wire logic irq_ack_i,
	output logic irq_o,
	// analog conversion core
	output cs_core_ctrl_t core_ctrl_o,
	output logic conv_clk_o,
	input wire logic [CS_RES_W-1:0] core_result_i,
	// trigger flags of other peripherals, bit 0 unused
	input wire logic [7:0] trig_flags_i,
	// analog pins used as digital inputs
	input wire logic [N_PINS-1:0] port_pins_i,
	output logic [N_PINS-1:0] port_pins_o,
	output logic [N_PINS-1:0] pin_input_disable_o
);

	// elaboration check
	if (N_PINS < 1 || N_PINS > 8) begin : g_bad_pins
		$error("N_PINS must be 1 to 8");
	end

	// bus handshake
	logic ack;
	logic req;
	logic wr_en;
	logic rd_en;
	logic [7:0] idx;
	logic [7:0] wd;
	logic wr_a;
	// registers
	logic enable;
	logic auto_trig;
	logic irq_en;
	logic [2:0] prescale;
	logic done_flag;
	logic [2:0] trig_sel;
	cs_mux_t mux_reg;
	cs_mux_t active_mux;
	logic [N_PINS-1:0] pin_dis;
	logic [CS_RES_W-1:0] result;
	logic locked;
	logic first_pending;
	// sequencer
	cs_state_t state;
	logic [4:0] tick_cnt;
	logic [4:0] conv_len;
	logic tick;
	logic trig_edge;
	logic next_enable;
	logic sw_start;
	logic trig_start;
	logic start_now;
	logic done_evt;
	logic free_again;
	logic rd_low;
	logic rd_high;
	logic [7:0] res_low_view;
	logic [7:0] res_high_view;
	logic [7:0] rd_byte;
	logic [N_PINS-1:0] masked_pins;
	// one wait state for every access
	assign req = avs_read_i || avs_write_i;
	assign avs_waitrequest_o = req && !ack;
	assign wr_en = avs_write_i && ack && avs_byteenable_i[0];
	assign rd_en = avs_read_i && ack;
	assign idx = avs_address_i[CS_ADDR_W-1:2];
	assign wd = avs_writedata_i[7:0];
	assign wr_a = wr_en && (idx == CS_IDX_CTRL_A);
	assign rd_low = rd_en && (idx == CS_IDX_RES_LOW);
	assign rd_high = rd_en && (idx == CS_IDX_RES_HIGH);

	// acknowledge flop
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack <= 1'b0;
		end else begin
			ack <= req && !ack;
		end
	end

	// result presentation follows left adjust at once
	always_comb begin
		if (mux_reg.left_adjust) begin // R22
			res_high_view = result[9:2]; // R11
			res_low_view = {result[1:0], 6'h00}; // R11
		end else begin
			res_high_view = {6'h00, result[9:8]}; // R10
			res_low_view = result[7:0]; // R10
		end
	end

	// read multiplexer, unmapped indices read zero
	always_comb begin
		case (idx)
			CS_IDX_RES_LOW: rd_byte = res_low_view;
			CS_IDX_RES_HIGH: rd_byte = res_high_view;
			CS_IDX_CTRL_A: rd_byte = {enable, state == CS_BUSY, auto_trig,
				done_flag, irq_en, prescale}; // R3
			CS_IDX_CTRL_B: rd_byte = {5'h00, trig_sel};
			CS_IDX_MUX: rd_byte = mux_reg;
			CS_IDX_PIN_DIS: rd_byte = 8'(pin_dis);
			default: rd_byte = CS_RST_BYTE;
		endcase
	end

	// read data captured in the wait cycle, valid at the acknowledge edge
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			avs_readdata_o <= '0;
		end else if (avs_read_i && !ack) begin
			avs_readdata_o <= {24'h000000, rd_byte};
		end
	end

	// software configuration registers
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			enable <= 1'b0;
			auto_trig <= 1'b0;
			irq_en <= 1'b0;
			prescale <= 3'h0;
			trig_sel <= 3'h0;
			mux_reg <= CS_RST_BYTE;
			pin_dis <= '0;
		end else if (wr_en) begin
			case (idx)
				CS_IDX_CTRL_A: begin
					enable <= wd[7];
					auto_trig <= wd[5];
					irq_en <= wd[3];
					prescale <= wd[2:0];
				end
				CS_IDX_CTRL_B: trig_sel <= wd[2:0]; // R14
				CS_IDX_MUX: mux_reg <= wd;
				CS_IDX_PIN_DIS: pin_dis <= wd[N_PINS-1:0];
				default: ;
			endcase
		end
	end
	assign next_enable = wr_a ? wd[7] : enable;
	// converter clock
	cs_prescale u_prescale (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.run_i(enable),
		.sel_i(prescale),
		.tick_o(tick),
		.conv_clk_o(conv_clk_o)
	);

	// trigger source edge
	cs_trig_edge u_trig (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.flags_i(trig_flags_i),
		.sel_i(trig_sel),
		.edge_o(trig_edge)
	);

	// start causes; a zero write to start does nothing
	assign sw_start = wr_a && wd[6] && wd[7]; // R1 R3
	assign trig_start = next_enable && auto_trig && trig_edge; // R4 R15
	assign start_now = (state == CS_IDLE) && (sw_start || trig_start);
	assign done_evt = (state == CS_BUSY) && tick
		&& (tick_cnt == conv_len - 5'h01);
	assign free_again = auto_trig && (trig_sel == CS_TRIG_FREE); // R23

	// sequencer state; disabling aborts at once
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= CS_IDLE;
		end else if (!next_enable) begin
			state <= CS_IDLE; // R20
		end else begin
			case (state)
				CS_IDLE: if (start_now) begin
					state <= CS_BUSY;
				end
				CS_BUSY: if (done_evt && !free_again) begin
					state <= CS_IDLE; // R3
				end
				default: state <= CS_IDLE;
			endcase
		end
	end

	// converter clock count and length of the running conversion
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tick_cnt <= 5'h00;
			conv_len <= CS_NORM_CYCLES;
		end else if (start_now) begin
			tick_cnt <= 5'h00;
			conv_len <= (first_pending || (wr_a && !enable))
				? CS_INIT_CYCLES : CS_NORM_CYCLES; // R2
		end else if (done_evt) begin
			tick_cnt <= 5'h00;
			conv_len <= CS_NORM_CYCLES; // R23
		end else if (state == CS_BUSY && tick) begin
			tick_cnt <= tick_cnt + 5'h01;
		end
	end

	// first conversion after enabling is the long one
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			first_pending <= 1'b0;
		end else if (!next_enable || start_now) begin
			first_pending <= 1'b0;
		end else if (wr_a && !enable) begin
			first_pending <= 1'b1; // R2
		end
	end

	// reference and channel follow the register only between conversions
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			active_mux <= CS_RST_BYTE;
		end else if (state != CS_BUSY || done_evt) begin
			active_mux <= mux_reg; // R21
		end
	end

	// commands to the analog core
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			core_ctrl_o <= '0;
		end else begin
			core_ctrl_o.start <= start_now || (done_evt && free_again);
			core_ctrl_o.init <= start_now && (first_pending
				|| (wr_a && !enable));
			core_ctrl_o.reference <= active_mux.reference;
			core_ctrl_o.channel <= active_mux.channel;
		end
	end

	// low byte read locks the result until the high byte is read
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			locked <= 1'b0;
		end else if (rd_high) begin
			locked <= 1'b0; // R12
		end else if (rd_low) begin
			locked <= 1'b1; // R12
		end
	end

	// result store
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			result <= CS_RST_RESULT;
		end else if (done_evt && (!locked || rd_high)) begin
			result <= core_result_i; // R5 R12
		end
	end

	// done flag: completion wins over any clear in the same cycle
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			done_flag <= 1'b0;
		end else if (done_evt) begin
			done_flag <= 1'b1; // R5
		end else if (irq_ack_i || (wr_a && wd[4])) begin
			done_flag <= 1'b0; // R6 R8
		end
	end
	assign irq_o = done_flag && irq_en && global_irq_enable_i; // R7
	// digital input masking per pin
	for (genvar g = 0; g < N_PINS; g++) begin : g_pin
		assign masked_pins[g] = pin_dis[g] ? 1'b0 : port_pins_i[g]; // R19
	end

	// registered pin readings and buffer disables
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			port_pins_o <= '0;
		end else begin
			port_pins_o <= masked_pins; // R19
		end
	end
	assign pin_input_disable_o = pin_dis; // R19
	// checks
	busy_reads_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R3
		state == CS_BUSY && idx == CS_IDX_CTRL_A |-> rd_byte[6])
		else $error("start bit not reading one during conversion");
	init_length_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R2
		start_now && (first_pending || (wr_a && !enable)) |=>
		conv_len == CS_INIT_CYCLES)
		else $error("first conversion not 25 cycles");
	norm_length_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R2
		start_now && !first_pending && !(wr_a && !enable) |=>
		conv_len == CS_NORM_CYCLES)
		else $error("normal conversion not 13 cycles");
	flag_sets_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R5
		done_evt |=> done_flag)
		else $error("done flag not set at completion");
	flag_clears_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R6
		irq_ack_i && !done_evt |=> !done_flag)
		else $error("acknowledge did not clear done flag");
	irq_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R7
		irq_o == (done_flag && irq_en && global_irq_enable_i))
		else $error("interrupt request mismatch");
	lock_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R12
		locked && !rd_high |=> $stable(result))
		else $error("locked result changed");
	abort_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R20
		wr_a && !wd[7] |=> state == CS_IDLE ##1 state == CS_IDLE)
		else $error("disable did not abort conversion");
	trig_starts_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R4
		state == CS_IDLE && enable && !wr_a && auto_trig && trig_edge
		|=> state == CS_BUSY ##1 core_ctrl_o.start == 1'b0)
		else $error("trigger edge did not start conversion");
	mux_frozen_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R21
		state == CS_BUSY && !done_evt |=> $stable(active_mux))
		else $error("channel changed during conversion");
	free_run_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R23
		done_evt && free_again && enable && !wr_a |=> state == CS_BUSY)
		else $error("free running did not restart");
	cov_sw_conv: cover property (@(posedge clk_i) disable iff (!nrst_i)
		sw_start ##[1:1000] done_evt);
	cov_trig_conv: cover property (@(posedge clk_i) disable iff (!nrst_i)
		trig_start && state == CS_IDLE);
	cov_locked_done: cover property (@(posedge clk_i) disable iff (!nrst_i)
		done_evt && locked);
	cov_irq: cover property (@(posedge clk_i) disable iff (!nrst_i) irq_o);
endmodule

// ---- rtl/cs_pkg.sv ----
// shared constants and types for the conversion sequencer and its registers
package cs_pkg;

	// register bus geometry: byte address is four times the register index
	localparam int CS_ADDR_W = 10;
	localparam int CS_DATA_W = 32;
	localparam int CS_RES_W = 10;

	// register indices
	localparam logic [7:0] CS_IDX_RES_LOW = 8'h78;
	localparam logic [7:0] CS_IDX_RES_HIGH = 8'h79;
	localparam logic [7:0] CS_IDX_CTRL_A = 8'h7a;
	localparam logic [7:0] CS_IDX_CTRL_B = 8'h7b;
	localparam logic [7:0] CS_IDX_MUX = 8'h7c;
	localparam logic [7:0] CS_IDX_PIN_DIS = 8'h7e;

	// reset values
	localparam logic [7:0] CS_RST_BYTE = 8'h00;
	localparam logic [9:0] CS_RST_RESULT = 10'h000;

	// conversion lengths in converter clock cycles
	localparam logic [4:0] CS_INIT_CYCLES = 5'h19;
	localparam logic [4:0] CS_NORM_CYCLES = 5'h0d;

	// trigger source code that means free running
	localparam logic [2:0] CS_TRIG_FREE = 3'h0;

	// prescaler: code 0 divides like code 1
	localparam logic [7:0] CS_DIV_CODE0 = 8'h02;

	// sequencer states
	typedef enum logic [1:0] {
		CS_IDLE = 2'b01,
		CS_BUSY = 2'b10
	} cs_state_t;

	// control and status register a, msb first
	typedef struct packed {
		logic enable;
		logic start;
		logic auto_trig;
		logic done_flag;
		logic irq_en;
		logic [2:0] prescale;
	} cs_ctrl_a_t;

	// channel, reference and presentation register
	typedef struct packed {
		logic [1:0] reference;
		logic left_adjust;
		logic [4:0] channel;
	} cs_mux_t;

	// commands to the analog conversion core
	typedef struct packed {
		logic start;
		logic init;
		logic [1:0] reference;
		logic [4:0] channel;
	} cs_core_ctrl_t;

endpackage

// ---- rtl/cs_prescale.sv ----
// converter clock prescaler: divides the system clock by a selectable factor
module cs_prescale
	import cs_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// control
	input wire logic run_i,
	input wire logic [2:0] sel_i,
	// converter clock
	output logic tick_o,
	output logic conv_clk_o
);

	logic [7:0] div;
	logic [6:0] count;

	// division factor from the select code
	assign div = (sel_i == 3'h0) ? CS_DIV_CODE0 : (8'h01 << sel_i); // R9

	// one tick per converter clock period; >= recovers after a smaller code
	assign tick_o = run_i && ({1'b0, count} >= (div - 8'h01)); // R9

	// period counter, held at zero while the converter is off
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count <= 7'h00;
		end else if (!run_i || tick_o) begin
			count <= 7'h00;
		end else begin
			count <= count + 7'h01;
		end
	end

	// divided clock seen by the analog core, high in the first half period
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			conv_clk_o <= 1'b0;
		end else begin
			conv_clk_o <= run_i && ({1'b0, count} < (div >> 1));
		end
	end

	div_two_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R9
		tick_o && run_i && sel_i == 3'h1 |=> !tick_o ##1
		(tick_o || !run_i || sel_i != 3'h1))
		else $error("prescaler code 1 does not divide by two");

endmodule

// ---- rtl/cs_trig_edge.sv ----
// trigger source selection and rising edge detection
module cs_trig_edge
	import cs_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// sources and selection
	input wire logic [7:0] flags_i,
	input wire logic [2:0] sel_i,
	// trigger event
	output logic edge_o
);

	logic level;
	logic level_prev;

	// free running code selects a constant low level, so it never triggers
	assign level = (sel_i == CS_TRIG_FREE) ? 1'b0 : flags_i[sel_i]; // R16 R18

	// previous selected level: a switch to a set source is an edge too
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			level_prev <= 1'b0;
		end else begin
			level_prev <= level;
		end
	end

	assign edge_o = level && !level_prev; // R17

	free_no_edge_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R18
		sel_i == CS_TRIG_FREE |-> !edge_o)
		else $error("free running selection produced a trigger");

endmodule

// ---- verif/cs_core_model.sv ----
// behavioural analog core: a new value and channel capture per start pulse
module cs_core_model
	import cs_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// commands from the sequencer
	input wire cs_core_ctrl_t ctrl_i,
	// conversion value and bookkeeping
	output logic [CS_RES_W-1:0] result_o,
	output int starts_o,
	output int inits_o,
	output logic [4:0] chan_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// value steps at every start so a stale result is always visible
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			result_o <= 10'h2a5;
			starts_o <= 0;
			inits_o <= 0;
			chan_o <= 5'h00;
		end else if (ctrl_i.start) begin
			result_o <= result_o + 10'h0c3;
			starts_o <= starts_o + 1;
			inits_o <= inits_o + int'(ctrl_i.init);
			chan_o <= ctrl_i.channel;
		end
	end
endmodule

// ---- verif/test_cs_conv_seq.sv ----
// self-checking testbench for the conversion sequencer register block
module test_cs_conv_seq
	import cs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_i, nrst_i, rd, wr, gie, ack, irq, wreq, irq_q, cclk;
	logic [9:0] addr;
	logic [31:0] wdata, rdata;
	logic [3:0] be;
	logic [7:0] trig, pin_in, pin_out, pin_dis, q;
	logic [9:0] res, v;
	cs_core_ctrl_t cc;
	logic [4:0] mch;
	int starts, inits, since, len, fail_count, cmp_count, s, k, dv, nt;
	logic [7:0] ix [7] = '{CS_IDX_RES_LOW, CS_IDX_RES_HIGH, CS_IDX_CTRL_A,
		CS_IDX_CTRL_B, CS_IDX_MUX, CS_IDX_PIN_DIS, 8'h7d};

	cs_conv_seq cs_conv_seq_i (.clk_i(clk_i), .nrst_i(nrst_i),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdata), .avs_byteenable_i(be),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.global_irq_enable_i(gie), .irq_ack_i(ack), .irq_o(irq),
		.core_ctrl_o(cc), .conv_clk_o(cclk), .core_result_i(res),
		.trig_flags_i(trig), .port_pins_i(pin_in), .port_pins_o(pin_out),
		.pin_input_disable_o(pin_dis));
	cs_core_model cs_core_model_i (.clk_i(clk_i), .nrst_i(nrst_i),
		.ctrl_i(cc), .result_o(res), .starts_o(starts), .inits_o(inits),
		.chan_o(mch));

	// clock
	always #12.5 clk_i = ~clk_i;

	// cycles from a core start pulse to the rise of the interrupt
	always @(posedge clk_i) begin
		since <= cc.start ? 0 : since + 1;
		if (irq && !irq_q)
			len <= since;
		irq_q <= irq;
	end

	task automatic print_verdict();
		if (fail_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic hang();
		fail_count++;
		$display("CHECK FAILED %0t wait ran out", $time);
		print_verdict();
	endtask

	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		addr <= {i, 2'b00};
		rd <= !w;
		wr <= w;
		wdata <= {24'h0, d};
		for (n = 0; n < 20; n++) begin
			@(posedge clk_i);
			if (wreq === 1'b0)
				break;
		end
		if (n == 20)
			hang();
		q = rdata[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	// the write lands at the acknowledge edge; let one edge pass so that
	// its effects are settled before anything looks at them
	task automatic wrr(input logic [7:0] i, input logic [7:0] d);
		bus(1'b1, i, d);
		cyc(1);
	endtask

	task automatic rdc(input logic [7:0] i, input logic [7:0] e);
		bus(1'b0, i, 8'h00);
		chk(q, e);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic wait_irq();
		int n;
		for (n = 0; n < 5000 && irq !== 1'b1; n++)
			@(posedge clk_i);
		if (n == 5000)
			hang();
		cyc(1);
	endtask

	task automatic wait_st(input int t);
		int n;
		for (n = 0; n < 3000 && starts < t; n++)
			@(posedge clk_i);
		if (n == 3000)
			hang();
	endtask

	// both result bytes read low first, as software must
	task automatic rd_res(input logic [9:0] r, input logic la);
		rdc(CS_IDX_RES_LOW, la ? {r[1:0], 6'h00} : r[7:0]);
		rdc(CS_IDX_RES_HIGH, la ? r[9:2] : {6'h00, r[9:8]});
	endtask

	// main sequence
	initial begin
		clk_i = 1'b0;
		nrst_i = 1'b0;
		{rd, wr, ack, irq_q} = 4'h0;
		gie = 1'b1;
		be = 4'h1;
		addr = 10'h000;
		wdata = 32'h0;
		trig = 8'h00;
		pin_in = 8'h5a;
		fail_count = 0;
		cmp_count = 0;
		since = 0;
		len = 0;
		cyc(3);
		nrst_i <= 1'b1;
		foreach (ix[i])
			rdc(ix[i], 8'h00);
		// every prescale code, zero-writes to start while busy
		for (k = 0; k < 8; k++) begin
			dv = (k == 0) ? 2 : (2 << (k - 1));
			nt = (k == 0) ? 25 : 13;
			wrr(CS_IDX_CTRL_A, 8'hd8 | k[7:0]);
			rdc(CS_IDX_CTRL_A, 8'hc8 | k[7:0]);
			wrr(CS_IDX_CTRL_A, 8'h88 | k[7:0]);
			rdc(CS_IDX_CTRL_A, 8'hc8 | k[7:0]);
			wait_irq();
			chk(8'(len >= nt * dv - dv - 3 && len <= nt * dv + 4), 8'h01);
			rdc(CS_IDX_CTRL_A, 8'h98 | k[7:0]);
			rd_res(res, 1'b0);
		end
		chk(8'(inits), 8'h01);
		// interrupt gating and acknowledge
		gie <= 1'b0;
		cyc(2);
		chk({7'h0, irq}, 8'h00);
		gie <= 1'b1;
		cyc(2);
		chk({7'h0, irq}, 8'h01);
		wrr(CS_IDX_CTRL_A, 8'h81);
		chk({7'h0, irq}, 8'h00);
		wrr(CS_IDX_CTRL_A, 8'h89);
		chk({7'h0, irq}, 8'h01);
		ack <= 1'b1;
		cyc(1);
		ack <= 1'b0;
		cyc(1);
		chk({7'h0, irq}, 8'h00);
		rdc(CS_IDX_CTRL_A, 8'h89);
		// channel change during a conversion waits for its end
		wrr(CS_IDX_MUX, 8'hc5);
		wrr(CS_IDX_CTRL_A, 8'hc9);
		wrr(CS_IDX_MUX, 8'h09);
		chk({3'h0, cc.channel}, 8'h05);
		chk({6'h0, cc.reference}, 8'h03);
		wait_irq();
		chk({3'h0, mch}, 8'h05);
		wrr(CS_IDX_CTRL_A, 8'hd9);
		wait_irq();
		chk({3'h0, mch}, 8'h09);
		chk({6'h0, cc.reference}, 8'h00);
		v = res;
		rd_res(v, 1'b0);
		wrr(CS_IDX_MUX, 8'h29);
		rd_res(v, 1'b1);
		// low byte read locks the result across a new conversion
		rdc(CS_IDX_RES_LOW, {v[1:0], 6'h00});
		wrr(CS_IDX_CTRL_A, 8'hd9);
		wait_irq();
		rdc(CS_IDX_RES_HIGH, v[9:2]);
		// pin disable masking and a write without byte lane 0
		wrr(CS_IDX_PIN_DIS, 8'h0f);
		cyc(2);
		chk(pin_out, 8'h50);
		chk(pin_dis, 8'h0f);
		be <= 4'h0;
		wrr(CS_IDX_CTRL_B, 8'h03);
		be <= 4'h1;
		rdc(CS_IDX_CTRL_B, 8'h00);
		// source select has no effect without auto trigger
		wrr(CS_IDX_CTRL_A, 8'h99);
		wrr(CS_IDX_CTRL_B, 8'h01);
		s = starts;
		trig <= 8'h02;
		cyc(8);
		chk(8'(starts - s), 8'h00);
		trig <= 8'h00;
		// trigger codes 1 to 7: another code's flag ignored, own edge starts
		for (k = 1; k < 8; k++) begin
			wrr(CS_IDX_CTRL_B, k[7:0]);
			wrr(CS_IDX_CTRL_A, 8'hb9);
			s = starts;
			trig <= 8'h01 << ((k % 7) + 1);
			cyc(6);
			chk(8'(starts - s), 8'h00);
			trig <= (8'h01 << ((k % 7) + 1)) | (8'h01 << k);
			wait_st(s + 1);
			wait_irq();
			trig <= 8'h00;
			cyc(2);
		end
		// switching to a source already set is an edge
		wrr(CS_IDX_CTRL_B, 8'h01);
		trig <= 8'h04;
		cyc(2);
		wrr(CS_IDX_CTRL_A, 8'hb9);
		s = starts;
		wrr(CS_IDX_CTRL_B, 8'h02);
		wait_st(s + 1);
		wait_irq();
		trig <= 8'h00;
		s = starts;
		wrr(CS_IDX_CTRL_B, 8'h00);
		cyc(8);
		chk(8'(starts - s), 8'h00);
		// free running from one start, then abort by disabling
		wrr(CS_IDX_CTRL_A, 8'hf9);
		wait_st(s + 3);
		wrr(CS_IDX_CTRL_A, 8'h00);
		cyc(2);
		s = starts;
		cyc(60);
		chk(8'(starts - s), 8'h00);
		bus(1'b0, CS_IDX_CTRL_A, 8'h00);
		chk(q & 8'hef, 8'h00);
		chk({7'h0, cclk}, 8'h00);
		print_verdict();
	end
endmodule
